/* File: rtl/sbc_ce_decode.sv */
module sbc_ce_decode #(
  parameter bit EXT_PROG = 1'b0
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Configuration.
  input wire sbc_pkg::sbc_mode_t mode,
  input wire sbc_pkg::sbc_size_t size,
  input wire logic [2:0] ce_enable,
  // Access in progress.
  input wire logic ext_access,
  input wire logic standby,
  input wire logic [23:0] acc_addr,
  input wire logic [2:0] port_data,
  // Pins and usable set.
  output logic [2:0] chip_select_pin,
  output logic [2:0] ce_usable
);
  import sbc_pkg::*;

  typedef struct packed {
    logic [2:0] pin;
  } sbc_dec_t;

  sbc_dec_t st_q;
  sbc_dec_t st_d;
  logic [2:0] hit;

  // Returns true when a lies within lo..hi inclusive.
  function automatic logic in_rng(input logic [23:0] a, input logic [23:0] lo,
                                  input logic [23:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  always_comb begin
    hit = 3'h0;
    ce_usable = 3'h0;
    unique case (mode)
      SBC_SINGLE: begin
        hit = 3'h0;
      end
      SBC_EXP64K: begin
        if (!EXT_PROG) begin
          unique case (size)
            SBC_SIZE_64K: begin
              ce_usable = 3'h0;
            end
            SBC_SIZE_32K: begin
              ce_usable = 3'h1;
              hit[0] = in_rng(acc_addr, 24'h00_8000, 24'h00_efff);
            end
            SBC_SIZE_16K: begin
              ce_usable = 3'h3;
              hit[0] = in_rng(acc_addr, 24'h00_7000, 24'h00_afff);
              hit[1] = in_rng(acc_addr, 24'h00_b000, 24'h00_efff);
            end
            SBC_SIZE_8K: begin
              ce_usable = 3'h7;
              hit[0] = in_rng(acc_addr, 24'h00_8000, 24'h00_9fff);
              hit[1] = in_rng(acc_addr, 24'h00_a000, 24'h00_bfff);
              hit[2] = in_rng(acc_addr, 24'h00_c000, 24'h00_dfff);
            end
          endcase
        end else begin
          unique case (size)
            SBC_SIZE_64K: begin
              ce_usable = 3'h1;
              hit[0] = in_rng(acc_addr, 24'h00_0000, 24'h00_efff);
            end
            SBC_SIZE_32K: begin
              ce_usable = 3'h3;
              hit[0] = in_rng(acc_addr, 24'h00_0000, 24'h00_7fff);
              hit[1] = in_rng(acc_addr, 24'h00_8000, 24'h00_efff);
            end
            SBC_SIZE_16K: begin
              ce_usable = 3'h7;
              hit[0] = in_rng(acc_addr, 24'h00_0000, 24'h00_3fff);
              hit[1] = in_rng(acc_addr, 24'h00_4000, 24'h00_7fff);
              hit[2] = in_rng(acc_addr, 24'h00_8000, 24'h00_bfff);
            end
            SBC_SIZE_8K: begin
              ce_usable = 3'h7;
              hit[0] = in_rng(acc_addr, 24'h00_0000, 24'h00_1fff);
              hit[1] = in_rng(acc_addr, 24'h00_2000, 24'h00_3fff);
              hit[2] = in_rng(acc_addr, 24'h00_4000, 24'h00_5fff);
            end
          endcase
        end
      end
      SBC_EXP4M_MIN, SBC_EXP4M_MAX: begin
        ce_usable = 3'h7;
        if (EXT_PROG) begin
          hit[0] = in_rng(acc_addr, 24'h00_0000, 24'h00_efff)
                   || in_rng(acc_addr, 24'h01_0000, 24'h3f_ffff);
        end else begin
          hit[0] = in_rng(acc_addr, 24'hc0_0000, 24'hff_ffff);
        end
        hit[1] = in_rng(acc_addr, 24'h40_0000, 24'h7f_ffff);
        hit[2] = in_rng(acc_addr, 24'h80_0000, 24'hbf_ffff);
      end
    endcase
  end

  // Each pin is an active-low chip enable or the plain port data.
  always_comb begin
    st_d = st_q;
    if (clk_en) begin
      for (int i = 0; i < 3; i++) begin
        if (ce_enable[i]) begin
          st_d.pin[i] = !(hit[i] && ext_access && !standby);
        end else begin
          st_d.pin[i] = port_data[i];
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{pin: 3'h7};
    end else begin
      st_q <= st_d;
    end
  end

  assign chip_select_pin = st_q.pin;

endmodule

/* File: rtl/sbc_pkg.sv */
package sbc_pkg;

  // Bus modes as held in the two-bit bus mode field.
  typedef enum logic [1:0] {
    SBC_SINGLE = 2'b00,
    SBC_EXP64K = 2'b01,
    SBC_EXP4M_MIN = 2'b10,
    SBC_EXP4M_MAX = 2'b11
  } sbc_mode_t;

  // Chip size codes of the expanded 64K chip enable split.
  typedef enum logic [1:0] {
    SBC_SIZE_8K = 2'b00,
    SBC_SIZE_16K = 2'b01,
    SBC_SIZE_32K = 2'b10,
    SBC_SIZE_64K = 2'b11
  } sbc_size_t;

  // Register indices; the byte address is four times the index.
  localparam logic [15:0] SBC_IDX_CFG0 = 16'hff00;
  localparam logic [15:0] SBC_IDX_CFG1 = 16'hff01;
  localparam logic [15:0] SBC_IDX_STAT = 16'hff02;
  localparam int SBC_BYTES_PER_REG = 4;

  // Field positions of the first configuration register.
  localparam int SBC_MODE_LSB = 6;
  localparam int SBC_SIZE_LSB = 4;
  localparam int SBC_CE_LSB = 0;

  // Field positions of the second configuration register.
  localparam int SBC_WAIT_LSB = 4;
  localparam int SBC_CLKSEL_BIT = 3;
  localparam int SBC_OSCON_BIT = 2;
  localparam int SBC_VOLT_LSB = 0;

  // Values after reset and writable bit masks.
  localparam logic [7:0] SBC_CFG0_RST = 8'h37;
  localparam logic [7:0] SBC_CFG1_RST = 8'h00;
  localparam logic [7:0] SBC_CFG0_WMASK = 8'hf7;
  localparam logic [7:0] SBC_CFG1_WMASK = 8'h3f;

  // Bus clock cycles per code step of the wait field.
  localparam logic [1:0] SBC_WAIT_CYC_PER_CODE = 2'h1;

  // Register state of the top module.
  typedef struct packed {
    logic [7:0] cfg0;
    logic [7:0] cfg1;
    logic wrote0;
    logic wrote1;
    logic [31:0] rdata;
  } sbc_regs_t;

endpackage

/* File: rtl/sbc_top.sv */
// Function
// - Interrupts and NMI masked until both registers written.
// - Bus mode field selects four bus modes.
// - Single chip only without external program variant.
// - External program variant uses build-time expanded mode.
// - Reset clears bus mode field to zero.
// - Chip size field splits chip enables in 64K.
// - Usable chip enables depend on size and variant.
// - Chip size resets to 11; software reprograms.
// - Enable bits route chip enables or port data.
// - Chip enable bits reset to one, read back.
// - Wait field gives 12, 8, 4 or no states.
// - Twelve wait states equal three clock cycles.
// - Clock select bit picks fast or slow oscillator.
// - Chip enables only for external areas, high in standby.
// - Waits between T3 and T4, external fast only.
module sbc_top #(
  parameter bit EXT_PROG = 1'b0,
  parameter sbc_pkg::sbc_mode_t RESET_EXP_MODE = sbc_pkg::SBC_EXP4M_MAX,
  parameter int ADDR_W = 18
) (
  // Clock, reset and enable.
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt gate.
  input wire logic [7:0] irq_req,
  input wire logic nmi_req,
  output logic [7:0] irq_gated,
  output logic nmi_gated,
  // External bus cycle.
  input wire logic ext_access,
  input wire logic standby,
  input wire logic [23:0] acc_addr,
  input wire logic t3_pulse,
  output logic wait_hold,
  // Chip enable and port pins.
  input wire logic [2:0] port_data,
  output logic [2:0] chip_select_pin,
  output logic [2:0] ce_usable,
  // Mode and clock controls.
  output sbc_pkg::sbc_mode_t bus_mode_eff,
  output logic addr_low_bus_en,
  output logic addr_high_bus_en,
  output logic rd_wr_bus_en,
  output logic data_bus_en,
  output logic cpu_clock_select,
  output logic fast_osc_on,
  output logic [1:0] voltage_level
);
  import sbc_pkg::*;

  localparam logic [ADDR_W-1:0] ADDR_CFG0 =
    ADDR_W'(SBC_IDX_CFG0 * SBC_BYTES_PER_REG);
  localparam logic [ADDR_W-1:0] ADDR_CFG1 =
    ADDR_W'(SBC_IDX_CFG1 * SBC_BYTES_PER_REG);
  localparam logic [ADDR_W-1:0] ADDR_STAT =
    ADDR_W'(SBC_IDX_STAT * SBC_BYTES_PER_REG);

  generate
    if (ADDR_W < 18) begin : g_bad_addr
      $error("ADDR_W must be at least 18");
    end
    if (EXT_PROG && (RESET_EXP_MODE == SBC_SINGLE)) begin : g_bad_mode
      $error("External program variant needs an expanded reset mode");
    end
  endgenerate

  sbc_regs_t st_q;
  sbc_regs_t st_d;
  logic setup;
  logic access;
  logic hit0;
  logic hit1;
  logic hits;
  logic mapped;
  logic lifted;
  sbc_mode_t field_mode;
  sbc_size_t field_size;

  // Merges written bits under a mask so reserved bits stay zero.
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wr,
                                       input logic [7:0] mask);
    merge = (old & ~mask) | (wr & mask);
  endfunction

  // Bus decode.
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign hit0 = (paddr == ADDR_CFG0);
  assign hit1 = (paddr == ADDR_CFG1);
  assign hits = (paddr == ADDR_STAT);
  assign mapped = hit0 || hit1 || hits;

  // Zero-wait answer; a frozen clock stretches the access phase.
  assign pready = clk_en;
  assign pslverr = access && !mapped;
  assign prdata = st_q.rdata;

  // The gate opens once both configuration registers have been written.
  assign lifted = st_q.wrote0 && st_q.wrote1;
  assign irq_gated = lifted ? irq_req : 8'h00;
  assign nmi_gated = nmi_req && lifted;

  always_comb begin
    st_d = st_q;
    if (clk_en) begin
      if (setup) begin
        st_d.rdata = 32'h0000_0000;
        if (hit0) begin
          st_d.rdata[7:0] = st_q.cfg0;
        end else if (hit1) begin
          st_d.rdata[7:0] = st_q.cfg1;
        end else if (hits) begin
          st_d.rdata[3:0] = {lifted, bus_mode_eff, EXT_PROG};
          st_d.rdata[6:4] = ce_usable;
        end
      end
      if (access && pwrite && pstrb[0]) begin
        if (hit0) begin
          st_d.cfg0 = merge(st_q.cfg0, pwdata[7:0], SBC_CFG0_WMASK);
          st_d.wrote0 = 1'b1;
        end
        if (hit1) begin
          st_d.cfg1 = merge(st_q.cfg1, pwdata[7:0], SBC_CFG1_WMASK);
          st_d.wrote1 = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{
        cfg0: SBC_CFG0_RST,
        cfg1: SBC_CFG1_RST,
        wrote0: 1'b0,
        wrote1: 1'b0,
        rdata: 32'h0000_0000
      };
    end else begin
      st_q <= st_d;
    end
  end

  // Field extraction.
  assign field_mode = sbc_mode_t'(st_q.cfg0[SBC_MODE_LSB +: 2]);
  assign field_size = sbc_size_t'(st_q.cfg0[SBC_SIZE_LSB +: 2]);

  // A zero field means single chip, or the build-time mode in the other variant.
  always_comb begin
    if (field_mode == SBC_SINGLE && EXT_PROG) begin
      bus_mode_eff = RESET_EXP_MODE;
    end else begin
      bus_mode_eff = field_mode;
    end
  end

  // Pin function follows the effective bus mode.
  assign addr_low_bus_en = (bus_mode_eff != SBC_SINGLE);
  assign rd_wr_bus_en = (bus_mode_eff != SBC_SINGLE);
  assign data_bus_en = (bus_mode_eff != SBC_SINGLE);
  assign addr_high_bus_en = (bus_mode_eff == SBC_EXP4M_MIN)
                            || (bus_mode_eff == SBC_EXP4M_MAX);

  // Clock and analog controls straight from storage.
  assign cpu_clock_select = st_q.cfg1[SBC_CLKSEL_BIT];
  assign fast_osc_on = st_q.cfg1[SBC_OSCON_BIT];
  assign voltage_level = st_q.cfg1[SBC_VOLT_LSB +: 2];

  sbc_ce_decode #(
    .EXT_PROG(EXT_PROG)
  ) u_ce (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .mode(bus_mode_eff),
    .size(field_size),
    .ce_enable(st_q.cfg0[SBC_CE_LSB +: 3]),
    .ext_access(ext_access),
    .standby(standby),
    .acc_addr(acc_addr),
    .port_data(port_data),
    .chip_select_pin(chip_select_pin),
    .ce_usable(ce_usable)
  );

  sbc_wait_gen u_wait (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .wait_code(st_q.cfg1[SBC_WAIT_LSB +: 2]),
    .fast_clk_sel(cpu_clock_select),
    .single_chip(bus_mode_eff == SBC_SINGLE),
    .ext_access(ext_access),
    .t3_pulse(t3_pulse),
    .wait_hold(wait_hold)
  );

endmodule

/* File: rtl/sbc_wait_gen.sv */
module sbc_wait_gen (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Configuration.
  input wire logic [1:0] wait_code,
  input wire logic fast_clk_sel,
  input wire logic single_chip,
  // Bus cycle.
  input wire logic ext_access,
  input wire logic t3_pulse,
  // Stretch request.
  output logic wait_hold
);
  import sbc_pkg::*;

  typedef struct packed {
    logic [3:0] cnt;
  } sbc_wait_t;

  sbc_wait_t st_q;
  sbc_wait_t st_d;
  logic allow;

  // Waits only on external accesses with the fast clock and an expanded mode.
  assign allow = ext_access && fast_clk_sel && !single_chip;

  always_comb begin
    st_d = st_q;
    if (clk_en) begin
      if (t3_pulse && allow) begin
        st_d.cnt = 4'(wait_code * SBC_WAIT_CYC_PER_CODE);
      end else if (st_q.cnt != 4'h0) begin
        st_d.cnt = st_q.cnt - 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{cnt: 4'h0};
    end else begin
      st_q <= st_d;
    end
  end

  // Holds the bus between T3 and T4 while the count runs.
  assign wait_hold = (st_q.cnt != 4'h0);

endmodule

/* File: test/sbc_bus_model.sv */
module sbc_bus_model (
  // Clock and request.
  input wire logic sys_clk,
  input wire logic start,
  input wire logic [23:0] addr,
  // Block side.
  input wire logic wait_hold,
  output logic ext_access,
  output logic t3_pulse,
  output logic [23:0] acc_addr,
  // Result.
  output logic done,
  output int waits
);
  timeunit 1ns;
  timeprecision 100ps;
  // One external cycle: address, T3 pulse, waits counted, then release.
  initial begin
    ext_access = 1'b0;
    t3_pulse = 1'b0;
    acc_addr = 24'h00_0000;
    done = 1'b0;
    waits = 0;
    forever begin
      @(posedge sys_clk);
      done <= 1'b0;
      if (start) begin
        ext_access <= 1'b1;
        acc_addr <= addr;
        @(posedge sys_clk);
        t3_pulse <= 1'b1;
        @(posedge sys_clk);
        t3_pulse <= 1'b0;
        waits = 0;
        @(posedge sys_clk);
        while (wait_hold === 1'b1) begin
          waits++;
          @(posedge sys_clk);
        end
        ext_access <= 1'b0;
        acc_addr <= ~addr;
        done <= 1'b1;
      end
    end
  end
endmodule

/* File: test/sbc_top_monitor.sv */
module sbc_top_monitor #(
  parameter int ADDR_W = 18
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register bus.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // Interrupt gate.
  input wire logic [7:0] irq_req,
  input wire logic nmi_req,
  input wire logic [7:0] irq_gated,
  input wire logic nmi_gated,
  // Bus cycle and pins.
  input wire logic ext_access,
  input wire logic standby,
  input wire logic t3_pulse,
  input wire logic wait_hold,
  input wire logic [2:0] port_data,
  input wire logic [2:0] chip_select_pin,
  input wire logic [2:0] ce_usable,
  // Controls.
  input wire sbc_pkg::sbc_mode_t bus_mode_eff,
  input wire logic cpu_clock_select,
  input wire logic fast_osc_on,
  input wire logic [1:0] voltage_level
);
  import sbc_pkg::*;
  localparam logic [ADDR_W-1:0] A0 = ADDR_W'(SBC_IDX_CFG0 * SBC_BYTES_PER_REG);
  localparam logic [ADDR_W-1:0] A1 = ADDR_W'(SBC_IDX_CFG1 * SBC_BYTES_PER_REG);
  logic [7:0] c0_q;
  logic [7:0] c1_q;
  logic w0_q;
  logic w1_q;
  logic wr;
  assign wr = psel && penable && pready && pwrite && pstrb[0];
  // Shadow copies of both registers and of the write flags.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      c0_q <= SBC_CFG0_RST;
      c1_q <= SBC_CFG1_RST;
      w0_q <= 1'b0;
      w1_q <= 1'b0;
    end else if (wr && paddr == A0) begin
      c0_q <= pwdata[7:0] & SBC_CFG0_WMASK;
      w0_q <= 1'b1;
    end else if (wr && paddr == A1) begin
      c1_q <= pwdata[7:0] & SBC_CFG1_WMASK;
      w1_q <= 1'b1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_t3_fast;
    t3_pulse && ext_access && c1_q[3] && bus_mode_eff != SBC_SINGLE;
  endsequence
  sequence s_hold3;
    wait_hold [*3] ##1 !wait_hold;
  endsequence
  chk_gate_mask: assert property (
    irq_gated == (irq_req & {8{w0_q & w1_q}}) && nmi_gated == (nmi_req & w0_q & w1_q))
    else $error("interrupt gate wrong");
  chk_mode_field: assert property (bus_mode_eff == c0_q[7:6])
    else $error("bus mode wrong");
  chk_clock_select: assert property (cpu_clock_select == c1_q[3])
    else $error("clock select wrong");
  chk_osc_level: assert property (
    fast_osc_on == c1_q[2] && voltage_level == c1_q[1:0])
    else $error("oscillator or level wrong");
  chk_usable_split: assert property (
    bus_mode_eff == SBC_EXP64K |-> ce_usable == 3'b111 >> c0_q[5:4])
    else $error("usable set wrong");
  chk_wait_max: assert property (s_t3_fast ##0 c1_q[5:4] == 2'b11 |=> s_hold3)
    else $error("long wait wrong");
  chk_wait_none: assert property (s_t3_fast ##0 c1_q[5:4] == 2'b00 |=> !wait_hold)
    else $error("wait without code");
  chk_wait_slow: assert property (t3_pulse && !c1_q[3] |=> !wait_hold [*4])
    else $error("wait on slow clock");
  chk_port_mode: assert property (
    c0_q[2:0] == 3'b000 |=> chip_select_pin == $past(port_data))
    else $error("port pins wrong");
  chk_standby_high: assert property (
    standby && c0_q[2:0] == 3'b111 |=> chip_select_pin == 3'b111)
    else $error("chip enable in standby");
endmodule

bind sbc_top sbc_top_monitor #(.ADDR_W(ADDR_W)) u_monitor (.sys_clk, .rst_n, .psel,
  .penable, .pwrite, .pready, .paddr, .pwdata, .pstrb, .irq_req, .nmi_req, .irq_gated,
  .nmi_gated, .ext_access, .standby, .t3_pulse, .wait_hold, .port_data, .chip_select_pin,
  .ce_usable, .bus_mode_eff, .cpu_clock_select, .fast_osc_on, .voltage_level);

/* File: test/tb_system_bus_config_regs.sv */
`define CHK(nm, ex, gt) \
  begin \
    num_checks++; \
    if ((gt) !== (ex)) begin \
      fail_count++; \
      $display("mismatch %s expected %h seen %h", nm, ex, gt); \
    end \
  end

module tb_system_bus_config_regs;
  timeunit 1ns;
  timeprecision 100ps;
  import sbc_pkg::*;
  localparam logic [17:0] A0 = 18'h3_fc00;
  localparam logic [17:0] A1 = 18'h3_fc04;
  localparam logic [17:0] AX = 18'h3_fc0c;
  logic sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, standby = 1'b0, start = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, nmi_req = 1'b0;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'hf;
  logic [7:0] irq_req = '0;
  logic [2:0] port_data = '0;
  logic [23:0] bus_a = '0;
  logic [31:0] prdata;
  logic pready, pslverr, nmi_gated, ext_access, t3_pulse, wait_hold, done, err;
  logic cpu_clock_select, fast_osc_on, lo_en, hi_en, rw_en, db_en;
  logic [1:0] voltage_level;
  logic [7:0] irq_gated, r, d, e;
  logic [23:0] acc_addr;
  logic [2:0] chip_select_pin, ce_usable, pin;
  sbc_mode_t bus_mode_eff;
  int fail_count = 0, num_checks = 0, w;
  logic [23:0] addr_tab [4] = '{24'h00_8100, 24'h00_a100, 24'h00_c100, 24'h00_f100};
  logic [2:0] pin_tab [4] = '{3'b110, 3'b101, 3'b011, 3'b111};

  sbc_top DUT (.sys_clk, .rst_n, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .irq_req, .nmi_req, .irq_gated, .nmi_gated, .ext_access,
    .standby, .acc_addr, .t3_pulse, .wait_hold, .port_data, .chip_select_pin, .ce_usable,
    .bus_mode_eff, .addr_low_bus_en(lo_en), .addr_high_bus_en(hi_en), .rd_wr_bus_en(rw_en),
    .data_bus_en(db_en), .cpu_clock_select, .fast_osc_on, .voltage_level);
  sbc_bus_model u_bus (.sys_clk, .start, .addr(bus_a), .wait_hold, .ext_access,
    .t3_pulse, .acc_addr, .done, .waits(w));

  // Twelve, eight or four quarter-cycle states give three, two or one cycles.
  function automatic int exp_waits(logic [7:0] c0, logic [7:0] c1);
    int states;
    states = 4 * c1[5:4];
    return (c0[7:6] == 2'b00 || !c1[3]) ? 0 : states / 4;
  endfunction

  task automatic apb(input logic [17:0] a, input logic wr, input logic [7:0] wd);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge sys_clk);
    r = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run_bus(input logic [23:0] a);
    int n;
    @(posedge sys_clk);
    start <= 1'b1;
    bus_a <= a;
    @(posedge sys_clk);
    start <= 1'b0;
    @(negedge sys_clk);
    @(negedge sys_clk);
    pin = chip_select_pin;
    for (n = 0; n < 20 && done !== 1'b1; n++) @(negedge sys_clk);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    $display("mismatch watchdog expected end seen hang");
    stop_test();
  end

  initial begin
    void'($urandom(32'h52eb));
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    apb(A0, 1'b0, 8'h00);
    `CHK("cfg0 reset", 8'h37, r)
    apb(A1, 1'b0, 8'h00);
    `CHK("cfg1 reset", 8'h00, r)
    `CHK("mode reset", SBC_SINGLE, bus_mode_eff)
    irq_req <= 8'($urandom) | 8'h01;
    nmi_req <= 1'b1;
    apb(A0, 1'b1, 8'h37);
    @(negedge sys_clk);
    `CHK("gate one", 8'h00, irq_gated)
    `CHK("nmi one", 1'b0, nmi_gated)
    apb(A1, 1'b1, 8'h00);
    @(negedge sys_clk);
    `CHK("gate both", irq_req, irq_gated)
    `CHK("nmi both", 1'b1, nmi_gated)
    $display("test reset and gate done");
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      e = 8'($urandom);
      apb(A0, 1'b1, d);
      apb(A1, 1'b1, e);
      apb(A0, 1'b0, 8'h00);
      `CHK("cfg0", d & 8'hf7, r)
      apb(A1, 1'b0, 8'h00);
      `CHK("cfg1", e & 8'h3f, r)
      `CHK("mode", d[7:6], bus_mode_eff)
      `CHK("addr high", d[7], hi_en)
      `CHK("addr low", (d[7:6] != 2'b00), lo_en)
      `CHK("rd wr", (d[7:6] != 2'b00), rw_en)
      `CHK("data bus", (d[7:6] != 2'b00), db_en)
      `CHK("clock", e[3], cpu_clock_select)
      `CHK("osc", e[2], fast_osc_on)
      `CHK("level", e[1:0], voltage_level)
    end
    apb(AX, 1'b0, 8'h00);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 8'h00, r)
    $display("test registers done");
    for (int i = 0; i < 12; i++) begin
      d = (i < 4) ? 8'h47 : 8'($urandom);
      e = (i < 4) ? 8'(8'h08 | (i << 4)) : 8'($urandom);
      apb(A0, 1'b1, d);
      apb(A1, 1'b1, e);
      run_bus(24'h00_8100);
      `CHK("waits", exp_waits(d, e), w)
    end
    $display("test waits done");
    apb(A0, 1'b1, 8'h47);
    for (int i = 0; i < 4; i++) begin
      run_bus(addr_tab[i]);
      `CHK("ce pin", pin_tab[i], pin)
    end
    standby <= 1'b1;
    run_bus(24'h00_8100);
    `CHK("ce standby", 3'b111, pin)
    standby <= 1'b0;
    apb(A0, 1'b1, 8'h40);
    port_data <= 3'($urandom);
    @(negedge sys_clk);
    @(negedge sys_clk);
    `CHK("port pins", port_data, chip_select_pin)
    $display("test chip enables done");
    stop_test();
  end
endmodule
